// file: verilog/bcd_disp_pkg.sv
`default_nettype none
package bcd_disp_pkg;

   localparam int unsigned BIT_COUNT = 12;
   localparam int unsigned DIGITS = 4;
   localparam int unsigned DIGIT_W = 4;
   localparam int unsigned SEG_W = 7;
   localparam int unsigned FIFO_W = 1;
   localparam int unsigned FIFO_DEPTH = 4;

   localparam logic [3:0] ADJ_LIMIT = 4'h5;
   localparam logic [3:0] ADJ_ADD = 4'h3;
   localparam logic [3:0] REQ_RST = 4'h0;
   localparam logic [3:0] REQ_ONE = 4'h1;
   localparam logic [3:0] REQ_LAST = 4'hC;
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [15:0] DIGITS_RST = 16'h0000;
   localparam logic [6:0] SEG_BLANK = 7'h00;

   ////////////////////////////////////////////////////////////////
   // control counter codes
   typedef enum logic [3:0] {
      ST_DISPLAY = 4'b1101,
      ST_CLEAR = 4'b0111,
      ST_B01 = 4'b0011,
      ST_B02 = 4'b0001,
      ST_B03 = 4'b0000,
      ST_B04 = 4'b1000,
      ST_B05 = 4'b0100,
      ST_B06 = 4'b1010,
      ST_B07 = 4'b0101,
      ST_B08 = 4'b0010,
      ST_B09 = 4'b1001,
      ST_B10 = 4'b1100,
      ST_B11 = 4'b0110,
      ST_B12 = 4'b1011
   } ctl_t;

   localparam ctl_t CTL_RST = ST_DISPLAY;

   ////////////////////////////////////////////////////////////////
   // display carrier, segments gfedcba, active high
   typedef struct packed {
      logic en;
      logic [DIGITS-1:0][SEG_W-1:0] seg;
   } disp_t;

   localparam disp_t DISP_RST = '{en: 1'b1, seg: {DIGITS{7'h3F}}};

   localparam logic [9:0][6:0] SEG_TABLE = {
      7'h6F, 7'h7F, 7'h07, 7'h7D, 7'h6D,
      7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F
   };

endpackage
`default_nettype wire

// file: verilog/digit_adjust.sv
`timescale 1ns/1ps
`default_nettype none

module digit_adjust #(
   parameter bit ADJUST = 1'b1
) (
   input wire logic [3:0] digit_i,
   output logic [3:0] digit_o
);

   // add three to a digit of five or more, last digit untouched
   always_comb begin
      if (ADJUST && (digit_i >= bcd_disp_pkg::ADJ_LIMIT)) begin
         digit_o = digit_i + bcd_disp_pkg::ADJ_ADD;
      end else begin
         digit_o = digit_i;
      end
   end

endmodule

`default_nettype wire

// file: verilog/bit_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module bit_fifo #(
   parameter int unsigned WIDTH = 1,
   parameter int unsigned DEPTH = 4
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);

   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_state_t;

   fifo_state_t st_r;
   fifo_state_t st_nxt;
   logic push;
   logic pop;

   assign in_ready_o = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (st_r.cnt != '0);
   assign out_data_o = st_r.mem[st_r.rp];
   assign push = clk_en_i && in_valid_i && in_ready_o;
   assign pop = clk_en_i && out_valid_o && out_ready_i;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wp] = in_data_i;
         st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

`default_nettype wire

// file: verilog/serial_binary_to_bcd_display.sv
// Behaviour
// - start in display state enters clear state
// - segment outputs enabled only in display state
// - clear state zeroes all four digit registers
// - gate source and converter for twelve bits
// - after twelfth bit return to display state
// - display held until start goes high again
// - digits except last flagged at five or more
// - flagged digit adds three, then shifts
// - result is four parallel 8421 BCD digits
// - one seven-segment decoder per digit, four total
`timescale 1ns/1ps
`default_nettype none

module serial_binary_to_bcd_display #(
   parameter int unsigned FIFO_DEPTH = bcd_disp_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire logic start_i,
   input wire logic src_valid_i,
   input wire logic src_bit_i,
   output logic src_ready_o,
   output logic busy_o,
   output logic done_o,
   output logic [3:0] ctl_o,
   output logic [15:0] bcd_o,
   output bcd_disp_pkg::disp_t disp_o
);

   ////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      bcd_disp_pkg::ctl_t ctl;
      logic [15:0] digits;
      logic [3:0] req_cnt;
      logic done;
      bcd_disp_pkg::disp_t disp;
   } top_state_t;

   top_state_t st_r;
   top_state_t st_nxt;

   logic fifo_out_valid;
   logic fifo_out_ready;
   logic fifo_out_bit;
   logic fifo_in_ready;
   logic shifting;
   logic take_bit;
   logic [15:0] adj_digits;
   logic [15:0] shifted;

   ////////////////////////////////////////////////////////////////
   // seven-segment decode, blank above nine

   function automatic logic [6:0] seg_decode(input logic [3:0] d);
      logic [6:0] s;
      case (d)
         4'h0: s = 7'h3F;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5B;
         4'h3: s = 7'h4F;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6D;
         4'h6: s = 7'h7D;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7F;
         4'h9: s = 7'h6F;
         default: s = bcd_disp_pkg::SEG_BLANK;
      endcase
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////
   // incoming bit buffer

   bit_fifo #(
      .WIDTH(bcd_disp_pkg::FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_bit_fifo (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .clk_en_i(clk_en_i),
      .in_valid_i(src_valid_i && src_ready_o),
      .in_ready_o(fifo_in_ready),
      .in_data_i(src_bit_i),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_bit)
   );

   ////////////////////////////////////////////////////////////////
   // add-three cells

   genvar gi;
   generate
      for (gi = 0; gi < bcd_disp_pkg::DIGITS; gi++) begin : g_adj
         digit_adjust #(
            .ADJUST(gi != bcd_disp_pkg::DIGITS - 1)
         ) u_adj (
            .digit_i(st_r.digits[gi*4 +: 4]),
            .digit_o(adj_digits[gi*4 +: 4])
         );
      end
   endgenerate

   // corrected digits shift one place, new bit enters at bottom
   assign shifted = {adj_digits[14:0], fifo_out_bit};

   assign shifting = (st_r.ctl != bcd_disp_pkg::ST_DISPLAY) &&
                     (st_r.ctl != bcd_disp_pkg::ST_CLEAR);
   assign take_bit = clk_en_i && shifting && fifo_out_valid;
   assign fifo_out_ready = shifting;

   // source gated until twelve bits handed over
   assign src_ready_o = clk_en_i && shifting && fifo_in_ready &&
                        (st_r.req_cnt != bcd_disp_pkg::REQ_LAST);

   ////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (clk_en_i) begin
         unique case (st_r.ctl)
            bcd_disp_pkg::ST_DISPLAY: begin
               if (start_i) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_CLEAR;
               end
            end
            bcd_disp_pkg::ST_CLEAR: begin
               st_nxt.digits = bcd_disp_pkg::DIGITS_RST;
               st_nxt.req_cnt = bcd_disp_pkg::REQ_RST;
               st_nxt.ctl = bcd_disp_pkg::ST_B01;
            end
            bcd_disp_pkg::ST_B01: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_B02;
               end
            end
            bcd_disp_pkg::ST_B02: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_B03;
               end
            end
            bcd_disp_pkg::ST_B03: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_B04;
               end
            end
            bcd_disp_pkg::ST_B04: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_B05;
               end
            end
            bcd_disp_pkg::ST_B05: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_B06;
               end
            end
            bcd_disp_pkg::ST_B06: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_B07;
               end
            end
            bcd_disp_pkg::ST_B07: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_B08;
               end
            end
            bcd_disp_pkg::ST_B08: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_B09;
               end
            end
            bcd_disp_pkg::ST_B09: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_B10;
               end
            end
            bcd_disp_pkg::ST_B10: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_B11;
               end
            end
            bcd_disp_pkg::ST_B11: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_B12;
               end
            end
            bcd_disp_pkg::ST_B12: begin
               if (take_bit) begin
                  st_nxt.ctl = bcd_disp_pkg::ST_DISPLAY;
                  st_nxt.done = 1'b1;
               end
            end
            default: begin
               st_nxt.ctl = bcd_disp_pkg::ST_DISPLAY;
            end
         endcase
         // one shift per bit taken from the buffer
         if (take_bit) begin
            st_nxt.digits = shifted;
         end
         if (src_ready_o && src_valid_i) begin
            st_nxt.req_cnt = st_r.req_cnt + bcd_disp_pkg::REQ_ONE;
         end
         // decoders follow the next counter state
         st_nxt.disp.en = (st_nxt.ctl == bcd_disp_pkg::ST_DISPLAY);
         for (int i = 0; i < bcd_disp_pkg::DIGITS; i++) begin
            if (st_nxt.disp.en) begin
               st_nxt.disp.seg[i] = seg_decode(st_nxt.digits[i*4 +: 4]);
            end else begin
               st_nxt.disp.seg[i] = bcd_disp_pkg::SEG_BLANK;
            end
         end
      end else begin
         st_nxt.done = st_r.done;
      end
   end

   ////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r.ctl <= bcd_disp_pkg::CTL_RST;
         st_r.digits <= bcd_disp_pkg::DIGITS_RST;
         st_r.req_cnt <= bcd_disp_pkg::REQ_RST;
         st_r.done <= 1'b0;
         st_r.disp <= bcd_disp_pkg::DISP_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs

   assign busy_o = (st_r.ctl != bcd_disp_pkg::ST_DISPLAY);
   assign done_o = st_r.done;
   assign ctl_o = st_r.ctl;
   assign bcd_o = st_r.digits;
   assign disp_o = st_r.disp;

endmodule

`default_nettype wire

// file: bench/bin_source.sv
`timescale 1ns/1ps
`default_nettype none
module bin_source (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic ready_i,
   input wire logic load_i,
   input wire logic stall_i,
   input wire logic [11:0] value_i,
   output logic valid_o,
   output logic bit_o
);
   logic [11:0] word_r;
   logic [3:0] left_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         word_r <= 12'h000;
         left_r <= 4'h0;
         valid_o <= 1'b0;
      end else if (load_i) begin
         word_r <= value_i;
         left_r <= 4'hC;
         valid_o <= 1'b0;
      end else if (valid_o && ready_i && en_i) begin
         word_r <= {word_r[10:0], ~word_r[11]};
         left_r <= left_r - 4'h1;
         valid_o <= left_r > 4'h1 && !stall_i;
      end else if (!valid_o) begin
         valid_o <= left_r != 4'h0 && !stall_i;
      end
   end
   // idle line shows the inverse of the next bit
   assign bit_o = valid_o ? word_r[11] : ~word_r[11];
endmodule
`default_nettype wire

// file: bench/serial_binary_to_bcd_display_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module serial_binary_to_bcd_display_asserts (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire logic start_i,
   input wire logic src_valid_i,
   input wire logic src_bit_i,
   input wire logic src_ready_o,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic [3:0] ctl_o,
   input wire logic [15:0] bcd_o,
   input wire bcd_disp_pkg::disp_t disp_o
);
   localparam logic [55:0] SEQ = 56'hD731084A529C6B;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [3:0] taken_r;
   // bits handed over since the last clear
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         taken_r <= 4'h0;
      end else if (ctl_o == 4'h7) begin
         taken_r <= 4'h0;
      end else if (src_valid_i && src_ready_o && clk_en_i) begin
         taken_r <= taken_r + 4'h1;
      end
   end
   function automatic logic [3:0] succ(input logic [3:0] s);
      for (int i = 0; i < 14; i++) begin
         if (SEQ[55-4*i -: 4] == s) begin
            return SEQ[55-4*((i+1)%14) -: 4];
         end
      end
      return 4'hD;
   endfunction
   property p_start; ctl_o == 4'hD && start_i && clk_en_i |=> ctl_o == 4'h7; endproperty
   a_start: assert property (p_start) else $error("start");
   property p_en; disp_o.en == (ctl_o == 4'hD); endproperty
   a_en: assert property (p_en) else $error("enable");
   property p_clear; ctl_o == 4'h7 && clk_en_i |=> bcd_o == 16'h0000 && ctl_o == 4'h3; endproperty
   a_clear: assert property (p_clear) else $error("clear");
   property p_ready; src_ready_o |-> clk_en_i && ctl_o != 4'hD && ctl_o != 4'h7; endproperty
   a_ready: assert property (p_ready) else $error("gate");
   property p_done; $rose(done_o) |-> ctl_o == 4'hD && $past(ctl_o) == 4'hB; endproperty
   a_done: assert property (p_done) else $error("done");
   property p_hold; ctl_o == 4'hD && !(start_i && clk_en_i) |=> ctl_o == 4'hD && $stable(bcd_o); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_bcd; ctl_o == 4'hD |-> bcd_o[15:12] <= 4'h9 && bcd_o[11:8] <= 4'h9 && bcd_o[7:4] <= 4'h9
      && bcd_o[3:0] <= 4'h9; endproperty
   a_bcd: assert property (p_bcd) else $error("digit");
   property p_blank; !disp_o.en |-> disp_o.seg == '0; endproperty
   a_blank: assert property (p_blank) else $error("blank");
   property p_walk; $changed(ctl_o) |-> ctl_o == succ($past(ctl_o)); endproperty
   a_walk: assert property (p_walk) else $error("walk");
   property p_twelve; taken_r == 4'hC |-> !src_ready_o; endproperty
   a_twelve: assert property (p_twelve) else $error("twelve");
   property p_bits; $rose(done_o) |-> taken_r == 4'hC; endproperty
   a_bits: assert property (p_bits) else $error("bits");
   property p_digit; ctl_o != 4'hD |-> bcd_o[11:8] <= 4'h9 && bcd_o[7:4] <= 4'h9 && bcd_o[3:0] <= 4'h9;
      endproperty
   a_digit: assert property (p_digit) else $error("adjust");
   c_start: cover property (ctl_o == 4'h7);
   c_take: cover property (src_valid_i && src_ready_o && clk_en_i);
   c_done: cover property ($rose(done_o));
endmodule
bind serial_binary_to_bcd_display serial_binary_to_bcd_display_asserts i_chk (.ref_clk_i, .sys_rst_i, .clk_en_i,
   .start_i, .src_valid_i, .src_bit_i, .src_ready_o, .busy_o, .done_o, .ctl_o, .bcd_o, .disp_o);
`default_nettype wire

// file: bench/serial_binary_to_bcd_display_test.sv
`timescale 1ns/1ps
`default_nettype none
`define check(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
   $display("unexpected at %0t: %h %h", $time, a, b); end end
module serial_binary_to_bcd_display_test;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic clk_en_i = 1'b1, start_i = 1'b0, load = 1'b0, stall = 1'b0;
   logic src_valid, src_bit, src_ready, busy, done;
   logic [3:0] ctl;
   logic [15:0] bcd;
   logic [11:0] value = 12'h000;
   logic [11:0] corner [8] = '{12'h000, 12'hFFF, 12'h3E7, 12'h3E8, 12'h005, 12'h009, 12'h00A, 12'h7FF};
   bcd_disp_pkg::disp_t disp;
   int errors = 0, checked = 0, cycles = 0;
   always #50 ref_clk_i = ~ref_clk_i;
   serial_binary_to_bcd_display i_dut (.ref_clk_i, .sys_rst_i, .clk_en_i, .start_i, .src_valid_i(src_valid),
      .src_bit_i(src_bit), .src_ready_o(src_ready), .busy_o(busy), .done_o(done), .ctl_o(ctl), .bcd_o(bcd),
      .disp_o(disp));
   bin_source i_src (.clk_i(ref_clk_i), .rst_i(sys_rst_i), .en_i(clk_en_i), .ready_i(src_ready), .load_i(load),
      .stall_i(stall), .value_i(value), .valid_o(src_valid), .bit_o(src_bit));
   function automatic logic [15:0] to_bcd(input logic [11:0] v);
      return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction
   task automatic test_done;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic convert(input logic [11:0] v);
      int n;
      logic [15:0] want;
      n = 0;
      want = to_bcd(v);
      value <= v;
      load <= 1'b1;
      @(posedge ref_clk_i);
      load <= 1'b0;
      start_i <= 1'b1;
      do @(posedge ref_clk_i); while (!busy && ++n < 50);
      start_i <= 1'b0;
      `check(disp.en, 1'b0)
      do @(posedge ref_clk_i); while (!done && ++n < 400);
      `check(ctl, 4'hD)
      `check(bcd, want)
      for (int i = 0; i < 4; i++) begin
         `check(disp.seg[i], bcd_disp_pkg::SEG_TABLE[want[4*i+:4]])
      end
   endtask
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      clk_en_i <= ($urandom % 4) != 0;
      stall <= ($urandom % 3) == 0;
      if (cycles == 20000) begin
         errors++;
         test_done;
      end
   end
   initial begin
      void'($urandom(62));
      repeat (6) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      `check(disp, bcd_disp_pkg::DISP_RST)
      `check(busy, 1'b0)
      foreach (corner[i]) begin
         convert(corner[i]);
      end
      // reset in mid-conversion lands in the display state
      start_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      start_i <= 1'b0;
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      `check(disp, bcd_disp_pkg::DISP_RST)
      `check(ctl, 4'hD)
      `check(busy, 1'b0)
      repeat (24) begin
         convert(12'($urandom));
      end
      test_done;
   end
endmodule
`default_nettype wire
